// ---- flash_status_protect_reg.sv ----
// Status register one with block protection, write latch and busy handling
// Contract
// - Size code 000 none, 001..110 fractions, 111 all
// - Permanent lock freezes the protection-size field
// - Top/bottom select places the protected region
// - Operations run only while write latch set
// - Set-latch transaction sets write latch
// - Clear-latch transaction clears write latch
// - Successful operation end clears write latch
// - Any reset clears write latch
// - Busy flag one while operating, zero idle
// - Failure flags update while busy
// - Failure flag holds busy, refuses operations
// - Clear-flags transaction returns device to standby
// - Program failure or protected target sets flag
// - Erase failure or protected target sets flag
//
// Design decisions made here: the address map and the AHB-Lite register port.
`timescale 1ns/100ps
module flash_status_protect_reg (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        link_clk,
  input  wire logic        link_cs_n,
  input  wire logic        link_mosi,
  output logic             ready_busy_flag,
  output logic             irq
);

  flash_status_pkg::link_frame_s frame;
  logic                          frame_valid;
  logic                          is_protected;

  link_rx u_link_rx (
    .sys_clk     (sys_clk),
    .rst         (rst),
    .link_clk    (link_clk),
    .link_cs_n   (link_cs_n),
    .link_mosi   (link_mosi),
    .frame       (frame),
    .frame_valid (frame_valid)
  );

  // ------------------------------------------------------------------
  // Bus pipeline state
  // ------------------------------------------------------------------
  logic [7:0]  addr_ff;
  logic [7:0]  nxt_addr;
  logic        wr_pend_ff;
  logic        nxt_wr_pend;
  logic        rd_pend_ff;
  logic        nxt_rd_pend;
  logic        hready_ff;
  logic        nxt_hready;
  logic [31:0] hrdata_ff;
  logic [31:0] nxt_hrdata;
  logic        accept;

  // ------------------------------------------------------------------
  // Core state
  // ------------------------------------------------------------------
  flash_status_pkg::core_state_e state_ff;
  flash_status_pkg::core_state_e nxt_state;
  flash_status_pkg::op_kind_e    kind_ff;
  flash_status_pkg::op_kind_e    nxt_kind;
  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;
  logic [7:0] op_arg_ff;
  logic [7:0] nxt_op_arg;
  logic       op_fail_ff;
  logic       nxt_op_fail;
  logic       wel_ff;
  logic       nxt_wel;
  logic       prg_fail_ff;
  logic       nxt_prg_fail;
  logic       ers_fail_ff;
  logic       nxt_ers_fail;
  logic [2:0] size_v_ff;
  logic [2:0] nxt_size_v;
  logic [7:0] status_n_ff;
  logic [7:0] nxt_status_n;
  logic       lock_ff;
  logic       nxt_lock;
  logic       tb_ff;
  logic       nxt_tb;
  logic       inject_ff;
  logic       nxt_inject;
  logic       load_ff;
  logic [2:0] irq_st_ff;
  logic [2:0] nxt_irq_st;
  logic [2:0] irq_en_ff;
  logic [2:0] nxt_irq_en;
  logic       irq_ff;
  logic       nxt_irq;
  logic       busy_ff;
  logic       nxt_busy;
  logic [2:0] events;
  logic [2:0] irq_clr;
  logic       soft_rst;
  logic       is_op;
  logic [7:0] status_v;

  region_check u_region_check (
    .block_protect_size (size_v_ff),
    .top_bottom_select  (tb_ff),
    .block_addr         (frame.arg),
    .is_protected       (is_protected)
  );

  function automatic logic wr_hit(input logic [7:0] ofs);
    return wr_pend_ff && (addr_ff == ofs);
  endfunction

  always_comb begin
    status_v                                   = 8'h00;
    status_v[flash_status_pkg::BUSY_BIT]       = busy_ff;
    status_v[flash_status_pkg::WEL_BIT]        = wel_ff;
    status_v[flash_status_pkg::SIZE_LSB +: 3]  = size_v_ff;
    status_v[flash_status_pkg::ERS_FAIL_BIT]   = ers_fail_ff;
    status_v[flash_status_pkg::PRG_FAIL_BIT]   = prg_fail_ff;
  end

  // ------------------------------------------------------------------
  // Bus slave: writes land in the data phase, reads take one wait state
  // ------------------------------------------------------------------
  // The wait state lets a read that follows a write see the new value
  always_comb begin
    accept      = hsel && htrans[1] && hready;
    nxt_addr    = addr_ff;
    nxt_wr_pend = 1'b0;
    nxt_rd_pend = 1'b0;
    nxt_hready  = 1'b1;
    nxt_hrdata  = hrdata_ff;
    if (rd_pend_ff) begin
      nxt_hrdata = 32'h0000_0000;
      case (addr_ff)
        flash_status_pkg::OFS_STATUS_V:   nxt_hrdata[7:0] = status_v;
        flash_status_pkg::OFS_STATUS_N:   nxt_hrdata[7:0] = status_n_ff;
        flash_status_pkg::OFS_CONFIG: begin
          nxt_hrdata[flash_status_pkg::CFG_LOCK_BIT] = lock_ff;
          nxt_hrdata[flash_status_pkg::CFG_TB_BIT]   = tb_ff;
        end
        flash_status_pkg::OFS_CONTROL:    nxt_hrdata[flash_status_pkg::CTL_INJ_BIT] = inject_ff;
        flash_status_pkg::OFS_IRQ_STATUS: nxt_hrdata[2:0] = irq_st_ff;
        flash_status_pkg::OFS_IRQ_ENABLE: nxt_hrdata[2:0] = irq_en_ff;
        default:                          nxt_hrdata = 32'h0000_0000;
      endcase
    end else if (accept) begin
      nxt_addr    = haddr[7:0];
      nxt_wr_pend = hwrite;
      nxt_rd_pend = ~hwrite;
      nxt_hready  = hwrite;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      addr_ff    <= 8'h00;
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      hready_ff  <= 1'b1;
      hrdata_ff  <= 32'h0000_0000;
    end else begin
      addr_ff    <= nxt_addr;
      wr_pend_ff <= nxt_wr_pend;
      rd_pend_ff <= nxt_rd_pend;
      hready_ff  <= nxt_hready;
      hrdata_ff  <= nxt_hrdata;
    end
  end

  // ------------------------------------------------------------------
  // Core: transactions, embedded operations, flags, interrupts
  // ------------------------------------------------------------------
  always_comb begin
    nxt_state    = state_ff;
    nxt_kind     = kind_ff;
    nxt_cnt      = cnt_ff;
    nxt_op_arg   = op_arg_ff;
    nxt_op_fail  = op_fail_ff;
    nxt_wel      = wel_ff;
    nxt_prg_fail = prg_fail_ff;
    nxt_ers_fail = ers_fail_ff;
    nxt_size_v   = size_v_ff;
    nxt_status_n = status_n_ff;
    nxt_lock     = lock_ff;
    nxt_tb       = tb_ff;
    nxt_inject   = inject_ff;
    nxt_irq_en   = irq_en_ff;
    events       = 3'h0;
    irq_clr      = 3'h0;
    is_op        = (frame.opcode == flash_status_pkg::OPC_PROGRAM)
                || (frame.opcode == flash_status_pkg::OPC_ERASE)
                || (frame.opcode == flash_status_pkg::OPC_WRITE_REG);
    soft_rst     = (frame_valid && frame.opcode == flash_status_pkg::OPC_SOFT_RESET)
                || (wr_hit(flash_status_pkg::OFS_CONTROL)
                    && hwdata[flash_status_pkg::CTL_SRST_BIT]);

    // Software side of the register file
    if (wr_hit(flash_status_pkg::OFS_STATUS_N)) begin
      nxt_status_n = hwdata[7:0];
      nxt_status_n[7] = 1'b0;
      if (lock_ff) begin
        nxt_status_n[flash_status_pkg::SIZE_LSB +: 3] =
          status_n_ff[flash_status_pkg::SIZE_LSB +: 3];
      end
    end
    if (wr_hit(flash_status_pkg::OFS_CONFIG)) begin
      // The lock is one-way; it also freezes the region placement
      nxt_lock = lock_ff | hwdata[flash_status_pkg::CFG_LOCK_BIT];
      if (!lock_ff) begin
        nxt_tb = hwdata[flash_status_pkg::CFG_TB_BIT];
      end
    end
    if (wr_hit(flash_status_pkg::OFS_CONTROL)) begin
      nxt_inject = hwdata[flash_status_pkg::CTL_INJ_BIT];
    end
    if (wr_hit(flash_status_pkg::OFS_IRQ_CLEAR)) begin
      irq_clr = hwdata[2:0];
    end
    if (wr_hit(flash_status_pkg::OFS_IRQ_ENABLE)) begin
      nxt_irq_en = hwdata[2:0];
    end

    case (state_ff)
      flash_status_pkg::ST_IDLE: begin
        if (frame_valid) begin
          if (frame.opcode == flash_status_pkg::OPC_SET_WRITE_LATCH) begin
            nxt_wel = 1'b1;
          end else if (frame.opcode == flash_status_pkg::OPC_CLEAR_WRITE_LATCH) begin
            nxt_wel = 1'b0;
          end else if (is_op) begin
            if (!wel_ff || !frame.arg_valid) begin
              events[flash_status_pkg::IRQ_REFUSED] = 1'b1;
            end else begin
              nxt_state   = flash_status_pkg::ST_RUN;
              nxt_cnt     = 8'(flash_status_pkg::OP_CYCLES - 1);
              nxt_op_arg  = frame.arg;
              nxt_kind    = (frame.opcode == flash_status_pkg::OPC_PROGRAM)
                          ? flash_status_pkg::OP_PROGRAM
                          : (frame.opcode == flash_status_pkg::OPC_ERASE)
                          ? flash_status_pkg::OP_ERASE : flash_status_pkg::OP_WREG;
              // A protected program or erase target fails the operation, as does injected fault
              nxt_op_fail = inject_ff
                          || (is_protected
                              && frame.opcode != flash_status_pkg::OPC_WRITE_REG);
            end
          end
        end
      end
      flash_status_pkg::ST_RUN: begin
        if (frame_valid && frame.opcode != flash_status_pkg::OPC_SOFT_RESET) begin
          events[flash_status_pkg::IRQ_REFUSED] = 1'b1;
        end
        if (cnt_ff != 8'h00) begin
          nxt_cnt = cnt_ff - 8'h01;
        end else if (op_fail_ff) begin
          // Flags set while busy is still shown; busy then stays held
          if (kind_ff == flash_status_pkg::OP_ERASE) begin
            nxt_ers_fail = 1'b1;
          end else begin
            nxt_prg_fail = 1'b1;
          end
          nxt_state = flash_status_pkg::ST_FAIL;
          events[flash_status_pkg::IRQ_FAIL] = 1'b1;
        end else begin
          nxt_wel   = 1'b0;
          nxt_state = flash_status_pkg::ST_IDLE;
          events[flash_status_pkg::IRQ_DONE] = 1'b1;
          if (kind_ff == flash_status_pkg::OP_WREG && !lock_ff) begin
            nxt_size_v = op_arg_ff[flash_status_pkg::SIZE_LSB +: 3];
            nxt_status_n[flash_status_pkg::SIZE_LSB +: 3] =
              op_arg_ff[flash_status_pkg::SIZE_LSB +: 3];
          end
        end
      end
      flash_status_pkg::ST_FAIL: begin
        if (frame_valid && frame.opcode == flash_status_pkg::OPC_CLEAR_FAIL_FLAGS) begin
          nxt_prg_fail = 1'b0;
          nxt_ers_fail = 1'b0;
          nxt_state    = flash_status_pkg::ST_IDLE;
        end else if (frame_valid && frame.opcode != flash_status_pkg::OPC_SOFT_RESET) begin
          events[flash_status_pkg::IRQ_REFUSED] = 1'b1;
        end
      end
      default: begin
        nxt_state = flash_status_pkg::ST_IDLE;
      end
    endcase

    // Soft reset, and the first cycle after power-on reset, reload the size
    if (soft_rst || load_ff) begin
      nxt_state    = flash_status_pkg::ST_IDLE;
      nxt_wel      = 1'b0;
      nxt_prg_fail = 1'b0;
      nxt_ers_fail = 1'b0;
      nxt_size_v   = status_n_ff[flash_status_pkg::SIZE_LSB +: 3];
    end

    nxt_busy   = (nxt_state != flash_status_pkg::ST_IDLE);
    // A new event wins over a clear in the same cycle
    nxt_irq_st = (irq_st_ff & ~irq_clr) | events;
    nxt_irq    = |(nxt_irq_st & nxt_irq_en);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_ff    <= flash_status_pkg::ST_IDLE;
      kind_ff     <= flash_status_pkg::OP_PROGRAM;
      cnt_ff      <= 8'h00;
      op_arg_ff   <= 8'h00;
      op_fail_ff  <= 1'b0;
      wel_ff      <= 1'b0;
      prg_fail_ff <= 1'b0;
      ers_fail_ff <= 1'b0;
      size_v_ff   <= flash_status_pkg::STATUS_N_RST[flash_status_pkg::SIZE_LSB +: 3];
      status_n_ff <= flash_status_pkg::STATUS_N_RST;
      lock_ff     <= 1'b0;
      tb_ff       <= 1'b0;
      inject_ff   <= 1'b0;
      load_ff     <= 1'b1;
      irq_st_ff   <= 3'h0;
      irq_en_ff   <= flash_status_pkg::IRQ_EN_RST;
      irq_ff      <= 1'b0;
      busy_ff     <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      kind_ff     <= nxt_kind;
      cnt_ff      <= nxt_cnt;
      op_arg_ff   <= nxt_op_arg;
      op_fail_ff  <= nxt_op_fail;
      wel_ff      <= nxt_wel;
      prg_fail_ff <= nxt_prg_fail;
      ers_fail_ff <= nxt_ers_fail;
      size_v_ff   <= nxt_size_v;
      status_n_ff <= nxt_status_n;
      lock_ff     <= nxt_lock;
      tb_ff       <= nxt_tb;
      inject_ff   <= nxt_inject;
      load_ff     <= 1'b0;
      irq_st_ff   <= nxt_irq_st;
      irq_en_ff   <= nxt_irq_en;
      irq_ff      <= nxt_irq;
      busy_ff     <= nxt_busy;
    end
  end

  assign hreadyout       = hready_ff;
  assign hresp           = 1'b0;
  assign hrdata          = hrdata_ff;
  assign ready_busy_flag = busy_ff;
  assign irq             = irq_ff;

endmodule

// ---- flash_status_pkg.sv ----
// Shared constants, types and layouts of the status-one protection block
package flash_status_pkg;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int OP_TIME_NS    = 1000;
  localparam int OP_CYCLES     = (OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ------------------------------------------------------------------
  // Bus register offsets (byte addresses, low byte decoded)
  // ------------------------------------------------------------------
  localparam logic [7:0] OFS_STATUS_V   = 8'h00;
  localparam logic [7:0] OFS_STATUS_N   = 8'h04;
  localparam logic [7:0] OFS_CONFIG     = 8'h08;
  localparam logic [7:0] OFS_CONTROL    = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_CLEAR  = 8'h14;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h18;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int BUSY_BIT     = 0;
  localparam int WEL_BIT      = 1;
  localparam int SIZE_LSB     = 2;
  localparam int ERS_FAIL_BIT = 5;
  localparam int PRG_FAIL_BIT = 6;
  localparam int CFG_LOCK_BIT = 4;
  localparam int CFG_TB_BIT   = 5;
  localparam int CTL_SRST_BIT = 0;
  localparam int CTL_INJ_BIT  = 1;
  localparam int IRQ_DONE     = 0;
  localparam int IRQ_FAIL     = 1;
  localparam int IRQ_REFUSED  = 2;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] STATUS_N_RST = 8'h00;
  localparam logic [2:0] IRQ_EN_RST   = 3'h0;

  // ------------------------------------------------------------------
  // Link transaction opcodes
  // ------------------------------------------------------------------
  localparam logic [7:0] OPC_SET_WRITE_LATCH   = 8'h06;
  localparam logic [7:0] OPC_CLEAR_WRITE_LATCH = 8'h04;
  localparam logic [7:0] OPC_CLEAR_FAIL_FLAGS  = 8'h82;
  localparam logic [7:0] OPC_PROGRAM           = 8'h02;
  localparam logic [7:0] OPC_ERASE             = 8'hd8;
  localparam logic [7:0] OPC_WRITE_REG         = 8'h01;
  localparam logic [7:0] OPC_SOFT_RESET        = 8'hf0;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_FAIL = 2'b11
  } core_state_e;

  typedef enum logic [1:0] {
    OP_PROGRAM = 2'b00,
    OP_ERASE   = 2'b01,
    OP_WREG    = 2'b11
  } op_kind_e;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] arg;
    logic       arg_valid;
  } link_frame_s;

endpackage

// ---- link_rx.sv ----
// Serial transaction receiver: synchronises link pins and assembles frames
`timescale 1ns/100ps
module link_rx (
  input  wire logic                         sys_clk,
  input  wire logic                         rst,
  input  wire logic                         link_clk,
  input  wire logic                         link_cs_n,
  input  wire logic                         link_mosi,
  output flash_status_pkg::link_frame_s     frame,
  output logic                              frame_valid
);

  logic [2:0] clk_sync_ff;
  logic [2:0] nxt_clk_sync;
  logic [2:0] cs_sync_ff;
  logic [2:0] nxt_cs_sync;
  logic [1:0] mosi_sync_ff;
  logic [1:0] nxt_mosi_sync;
  logic [7:0] shift_ff;
  logic [7:0] nxt_shift;
  logic [2:0] bitcnt_ff;
  logic [2:0] nxt_bitcnt;
  logic [1:0] nbytes_ff;
  logic [1:0] nxt_nbytes;
  logic [7:0] opcode_ff;
  logic [7:0] nxt_opcode;
  logic [7:0] arg_ff;
  logic [7:0] nxt_arg;
  logic       valid_ff;
  logic       nxt_valid;
  logic       rise;
  logic       selected;
  logic       cs_end;
  logic [7:0] shifted;

  // ------------------------------------------------------------------
  // Edge finding and byte assembly
  // ------------------------------------------------------------------
  // Edges are judged on stages one and two only; stage zero feeds stage one alone
  always_comb begin
    nxt_clk_sync  = {clk_sync_ff[1:0], link_clk};
    nxt_cs_sync   = {cs_sync_ff[1:0], link_cs_n};
    nxt_mosi_sync = {mosi_sync_ff[0], link_mosi};
    selected      = ~cs_sync_ff[1];
    rise          = clk_sync_ff[1] & ~clk_sync_ff[2] & selected;
    cs_end        = cs_sync_ff[1] & ~cs_sync_ff[2];
    shifted       = {shift_ff[6:0], mosi_sync_ff[1]};
    nxt_shift     = shift_ff;
    nxt_bitcnt    = bitcnt_ff;
    nxt_nbytes    = nbytes_ff;
    nxt_opcode    = opcode_ff;
    nxt_arg       = arg_ff;
    nxt_valid     = 1'b0;
    // Counters hold through the end edge so the frame still shows its argument byte
    if (!selected && !cs_end) begin
      nxt_bitcnt = 3'h0;
      nxt_nbytes = 2'h0;
    end else if (rise) begin
      nxt_shift  = shifted;
      nxt_bitcnt = bitcnt_ff + 3'h1;
      if (bitcnt_ff == 3'h7) begin
        if (nbytes_ff == 2'h0) begin
          nxt_opcode = shifted;
        end else if (nbytes_ff == 2'h1) begin
          nxt_arg = shifted;
        end
        if (nbytes_ff != 2'h3) begin
          nxt_nbytes = nbytes_ff + 2'h1;
        end
      end
    end
    // A frame counts only once a whole opcode byte has arrived
    if (cs_end && nbytes_ff != 2'h0) begin
      nxt_valid = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      clk_sync_ff  <= 3'h0;
      cs_sync_ff   <= 3'h7;
      mosi_sync_ff <= 2'h0;
      shift_ff     <= 8'h00;
      bitcnt_ff    <= 3'h0;
      nbytes_ff    <= 2'h0;
      opcode_ff    <= 8'h00;
      arg_ff       <= 8'h00;
      valid_ff     <= 1'b0;
    end else begin
      clk_sync_ff  <= nxt_clk_sync;
      cs_sync_ff   <= nxt_cs_sync;
      mosi_sync_ff <= nxt_mosi_sync;
      shift_ff     <= nxt_shift;
      bitcnt_ff    <= nxt_bitcnt;
      nbytes_ff    <= nxt_nbytes;
      opcode_ff    <= nxt_opcode;
      arg_ff       <= nxt_arg;
      valid_ff     <= nxt_valid;
    end
  end

  assign frame.opcode    = opcode_ff;
  assign frame.arg       = arg_ff;
  assign frame.arg_valid = (nbytes_ff >= 2'h2);
  assign frame_valid     = valid_ff;

endmodule

// ---- region_check.sv ----
// Decodes the protection-size code into a protected block range
`timescale 1ns/100ps
module region_check (
  input  wire logic [2:0] block_protect_size,
  input  wire logic       top_bottom_select,
  input  wire logic [7:0] block_addr,
  output logic            is_protected
);

  // ------------------------------------------------------------------
  // Size decode: number of protected blocks out of 256
  // ------------------------------------------------------------------
  // 000 none, 001 one 64th, 010 one 32nd, doubling up to 111 all
  function automatic logic [8:0] prot_blocks(input logic [2:0] code);
    logic [8:0] n;
    n = 9'h000;
    if (code == 3'h7) begin
      n = 9'h100;
    end else if (code != 3'h0) begin
      n = 9'h004 << (code - 3'h1);
    end
    return n;
  endfunction

  logic [8:0] count;

  always_comb begin
    count = prot_blocks(block_protect_size);
    if (!top_bottom_select) begin
      is_protected = ({1'b0, block_addr} >= (9'h100 - count));
    end else begin
      is_protected = ({1'b0, block_addr} < count);
    end
  end

endmodule

// ---- flash_status_protect_reg_monitor.sv ----
// Bus and status checker for the status-one protection block
`timescale 1ns/100ps
module flash_status_protect_reg_chk (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       hsel,
  input wire logic [1:0] htrans,
  input wire logic       hwrite,
  input wire logic       hready,
  input wire logic       hreadyout,
  input wire logic       hresp,
  input wire logic       link_cs_n,
  input wire logic       ready_busy_flag,
  input wire logic       irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("bus response not okay");
  property p_rd_wait; hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait not one cycle");
  property p_wr_now; hsel && htrans[1] && hready && hwrite |=> hreadyout; endproperty
  a_wr_now: assert property (p_wr_now) else $error("write stalled");
  property p_wait_src; !hreadyout |-> $past(hsel && htrans[1] && !hwrite); endproperty
  a_wait_src: assert property (p_wait_src) else $error("wait without read");
  property p_wait_one; !hreadyout |=> hreadyout; endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait too long");
  property p_rst_idle; $fell(rst) |-> !ready_busy_flag && !irq; endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("outputs not idle after reset");
  property p_busy_run; $rose(ready_busy_flag) |-> ready_busy_flag[*8]; endproperty
  a_busy_run: assert property (p_busy_run) else $error("busy pulse too short");
  property p_busy_src; $rose(ready_busy_flag) |-> $past(link_cs_n, 2); endproperty
  a_busy_src: assert property (p_busy_src) else $error("busy inside a frame");
endmodule
bind flash_status_protect_reg flash_status_protect_reg_chk u_chk (.sys_clk(sys_clk),
  .rst(rst), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .link_cs_n(link_cs_n),
  .ready_busy_flag(ready_busy_flag), .irq(irq));

// ---- link_host_model.sv ----
// Host controller model that sends serial frames on the link
`timescale 1ns/100ps
module link_host_model (
  output logic link_clk,
  output logic link_cs_n,
  output logic link_mosi
);
  initial begin
    link_clk = 1'b0;
    link_cs_n = 1'b1;
    link_mosi = 1'b0;
  end
  // Clock stands still between frames; released data shows the inverse
  task automatic send(input logic [15:0] d, input int n);
    #7 link_cs_n = 1'b0;
    #80;
    for (int i = 15; i > 15 - n; i--) begin
      link_mosi = d[i];
      #80 link_clk = 1'b1;
      #80 link_clk = 1'b0;
    end
    #80 link_cs_n = 1'b1;
    link_mosi = ~link_mosi;
    #200;
  endtask
endmodule

// ---- test_flash_status_protect_reg.sv ----
// Self-checking bench for the status-one protection block
`timescale 1ns/100ps
module test_flash_status_protect_reg;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rv;
  logic        hreadyout, link_clk, link_cs_n, link_mosi, ready_busy_flag, irq;
  int          fail_count = 0;
  int          n_compared = 0;
  always #10 sys_clk = ~sys_clk;
  link_host_model lh (.link_clk(link_clk), .link_cs_n(link_cs_n), .link_mosi(link_mosi));
  flash_status_protect_reg dut (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(), .hrdata(hrdata), .link_clk(link_clk),
    .link_cs_n(link_cs_n), .link_mosi(link_mosi), .ready_busy_flag(ready_busy_flag), .irq(irq));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge sys_clk); while (!hreadyout);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (!hreadyout);
    rv = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(rv, e);
  endtask
  // Each frame is followed by time for the synchroniser to act
  task automatic fr(input logic [7:0] op, input logic [7:0] arg, input int n, input int w);
    lh.send({op, arg}, n);
    repeat (8 + w) @(posedge sys_clk);
  endtask
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge sys_clk);
    fail_count++;
    test_done;
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rd(8'h00, 32'h0);
    rd(8'hfc, 32'h0);
    ahb(1'b1, 8'h18, 32'h7);
    fr(8'h02, 8'h00, 16, 0);
    rd(8'h10, 32'h4);
    chk({31'h0, irq}, 32'h1);
    ahb(1'b1, 8'h14, 32'h7);
    rd(8'h00, 32'h0);
    fr(8'h06, 8'h00, 8, 0);
    rd(8'h00, 32'h2);
    fr(8'h04, 8'h00, 8, 0);
    rd(8'h00, 32'h0);
    fr(8'h06, 8'h00, 8, 0);
    fr(8'h01, 8'h04, 16, 60);
    rd(8'h00, 32'h4);
    ahb(1'b1, 8'h14, 32'h7);
    fr(8'h06, 8'h00, 8, 0);
    fr(8'h02, 8'hff, 16, 60);
    rd(8'h00, 32'h47);
    chk({31'h0, ready_busy_flag}, 32'h1);
    fr(8'h06, 8'h00, 8, 0);
    rd(8'h10, 32'h6);
    fr(8'h82, 8'h00, 8, 0);
    rd(8'h00, 32'h6);
    chk({31'h0, ready_busy_flag}, 32'h0);
    ahb(1'b1, 8'h08, 32'h20);
    fr(8'hd8, 8'hff, 16, 60);
    rd(8'h00, 32'h4);
    fr(8'h06, 8'h00, 8, 0);
    fr(8'hd8, 8'h00, 16, 60);
    rd(8'h00, 32'h27);
    fr(8'h82, 8'h00, 8, 0);
    ahb(1'b1, 8'h08, 32'h30);
    fr(8'h01, 8'h1c, 16, 60);
    rd(8'h00, 32'h4);
    rd(8'h08, 32'h30);
    ahb(1'b1, 8'h04, 32'hff);
    rd(8'h04, 32'h67);
    fr(8'h06, 8'h00, 8, 0);
    ahb(1'b1, 8'h0c, 32'h1);
    repeat (4) @(posedge sys_clk);
    rd(8'h00, 32'h4);
    ahb(1'b1, 8'h0c, 32'h2);
    fr(8'h06, 8'h00, 8, 0);
    fr(8'h01, 8'h00, 16, 60);
    rd(8'h00, 32'h47);
    fr(8'hf0, 8'h00, 8, 0);
    rd(8'h00, 32'h4);
    test_done;
  end
endmodule
